// ---- verilog/dpmt_sequencer.v ----
`timescale 1ns/1ns
`include "dpmt_defines.vh"

module dpmt_sequencer (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire req_valid_i,
  input wire req_write_i,
  input wire [`DPMT_COL_W-1:0] req_col_addr_i,
  input wire [`DPMT_DATA_W-1:0] req_wdata_i,
  input wire [1:0] page_wait_states_i,
  input wire [1:0] out_of_page_wait_select_i,
  input wire [`DPMT_REF_W-1:0] refresh_interval_i,
  input wire [`DPMT_DATA_W-1:0] dram_dq_i,
  output reg req_ready_o,
  output reg [`DPMT_DATA_W-1:0] rdata_o,
  output reg rdata_valid_o,
  output reg refresh_req_o,
  output reg busy_o,
  output reg dram_ras_n_o,
  output reg dram_cas_n_o,
  output reg dram_wr_n_o,
  output reg dram_rd_n_o,
  output reg [`DPMT_COL_W-1:0] dram_addr_o,
  output reg [`DPMT_DATA_W-1:0] dram_dq_o,
  output reg dram_dq_oe_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_PRE = 3'b010;
  localparam ST_COL = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] ws;
  reg [1:0] brw;
  reg [5:0] k;
  reg [5:0] pre_cnt;
  reg [5:0] cas_at;
  reg more;
  reg ending;
  reg cur_write;
  reg nxt_write;
  reg [`DPMT_COL_W-1:0] nxt_addr;
  reg [`DPMT_DATA_W-1:0] nxt_data;
  reg [1:0] wr_age;
  reg [1:0] ref_pre;
  reg [`DPMT_REF_W-1:0] ref_cnt;

  reg [5:0] asc;
  reg [5:0] casw;
  reg [5:0] cp;
  reg [5:0] wcs;
  reg [5:0] wch;
  reg [5:0] ds;
  reg [5:0] rch;
  reg [5:0] crp;

  // Settings are frozen for a whole burst; idle tracks the live inputs
  wire in_idle = (state == ST_IDLE);
  wire in_pre = (state == ST_PRE);
  wire in_col = (state == ST_COL);
  wire [1:0] ws_eff = in_idle ? page_wait_states_i : ws;
  wire [1:0] brw_eff = in_idle ? out_of_page_wait_select_i : brw;

  always @* begin
    case (ws_eff)
      `DPMT_WS1: begin
        asc = `DPMT_W1_ASC;
        casw = `DPMT_W1_CASW;
        cp = `DPMT_W1_CP;
        wcs = `DPMT_W1_WCS;
        wch = `DPMT_W1_WCH;
        ds = `DPMT_W1_DS;
        rch = `DPMT_W1_RCH;
      end
      `DPMT_WS2: begin
        asc = `DPMT_W2_ASC;
        casw = `DPMT_W2_CASW;
        cp = `DPMT_W2_CP;
        wcs = `DPMT_W2_WCS;
        wch = `DPMT_W2_WCH;
        ds = `DPMT_W2_DS;
        rch = `DPMT_W2_RCH;
      end
      default: begin
        // Unsupported codes fall back to the slowest set
        asc = `DPMT_W3_ASC;
        casw = `DPMT_W3_CASW;
        cp = `DPMT_W3_CP;
        wcs = `DPMT_W3_WCS;
        wch = `DPMT_W3_WCH;
        ds = `DPMT_W3_DS;
        rch = `DPMT_W3_RCH;
      end
    endcase
  end

  always @* begin
    case ({ws_eff, brw_eff})
      4'h4: crp = `DPMT_W1_CRP0;
      4'h5: crp = `DPMT_W1_CRP1;
      4'h6: crp = `DPMT_W1_CRP2;
      4'h7: crp = `DPMT_W1_CRP3;
      4'h8: crp = `DPMT_W2_CRP0;
      4'h9: crp = `DPMT_W2_CRP1;
      4'ha: crp = `DPMT_W2_CRP2;
      4'hb: crp = `DPMT_W2_CRP3;
      4'h0, 4'hc: crp = `DPMT_W3_CRP0;
      4'h1, 4'hd: crp = `DPMT_W3_CRP1;
      4'h2, 4'he: crp = `DPMT_W3_CRP2;
      default: crp = `DPMT_W3_CRP3;
    endcase
  end

  wire [5:0] p_len = casw + cp;
  wire [5:0] win_start = p_len - wcs;
  wire [5:0] rch_end = casw + rch;
  // Column strobe rises at k == casw, so the full gap is counted from there
  wire [5:0] rel_at = casw + crp;
  wire [5:0] wrap_at = cas_at - 6'h01;

  wire cand = in_col && !more && !ending && (k >= win_start);
  // A write after a read waits until the write strobe may fall
  wire blocked = !cur_write && req_write_i && (k < rch_end);
  wire accept_col = cand && req_valid_i && !blocked;
  wire end_col = cand && !req_valid_i;
  wire accept_idle = in_idle && req_valid_i;
  wire wrap = in_col && more && (k == wrap_at);
  wire release_row = in_col && ending && (k == rel_at);

  wire upcoming = in_pre || (in_col && (more || accept_col));
  wire [5:0] to_cas = in_pre ? pre_cnt : (cas_at - k);
  wire [5:0] to_cas_eff = accept_col ? wcs : to_cas;
  wire up_write = accept_col ? req_write_i : nxt_write;
  wire [`DPMT_COL_W-1:0] up_addr = accept_col ? req_col_addr_i : nxt_addr;
  wire [`DPMT_DATA_W-1:0] up_data = accept_col ? req_wdata_i : nxt_data;

  wire n_ras = in_pre || (in_col && !release_row);
  wire n_cas = in_col && (k < casw);
  wire wr_lead = upcoming && up_write && (to_cas_eff <= wcs);
  wire wr_hold = in_col && cur_write && (k < wch);
  wire rd_lead = upcoming && !up_write && (to_cas_eff <= asc);
  wire rd_hold = in_col && !cur_write && (k <= casw);
  wire addr_load = upcoming && (to_cas_eff == asc);
  wire data_load = upcoming && up_write && (to_cas_eff == ds);
  wire rd_capture = in_col && !cur_write && (k == casw);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (pre_cnt == 6'h01) begin
          next_state = ST_COL;
        end
      end
      ST_COL: begin
        if (release_row) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      ws <= `DPMT_WS3;
      brw <= 2'h0;
      k <= 6'h00;
      pre_cnt <= 6'h00;
      cas_at <= 6'h00;
      more <= 1'b0;
      ending <= 1'b0;
      cur_write <= 1'b0;
      nxt_write <= 1'b0;
      nxt_addr <= {`DPMT_COL_W{1'b0}};
      nxt_data <= {`DPMT_DATA_W{1'b0}};
    end else begin
      state <= next_state;
      if (accept_idle) begin
        ws <= page_wait_states_i;
        brw <= out_of_page_wait_select_i;
        pre_cnt <= wcs;
        ending <= 1'b0;
        more <= 1'b0;
      end else if (in_pre) begin
        pre_cnt <= pre_cnt - 6'h01;
      end
      if (accept_idle || accept_col) begin
        nxt_write <= req_write_i;
        nxt_addr <= req_col_addr_i;
        nxt_data <= req_wdata_i;
      end
      if (in_pre && (pre_cnt == 6'h01)) begin
        k <= 6'h00;
        cur_write <= nxt_write;
      end else if (wrap) begin
        // Next column starts as the strobe falls again
        k <= 6'h00;
        cur_write <= nxt_write;
        more <= 1'b0;
      end else if (in_col) begin
        k <= k + 6'h01;
      end
      if (accept_col) begin
        more <= 1'b1;
        cas_at <= k + wcs;
      end
      if (end_col) begin
        ending <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dram_ras_n_o <= 1'b1;
      dram_cas_n_o <= 1'b1;
      dram_wr_n_o <= 1'b1;
      dram_rd_n_o <= 1'b1;
      dram_addr_o <= {`DPMT_COL_W{1'b0}};
      dram_dq_o <= {`DPMT_DATA_W{1'b0}};
      dram_dq_oe_o <= 1'b0;
      wr_age <= 2'h0;
      req_ready_o <= 1'b0;
      rdata_o <= {`DPMT_DATA_W{1'b0}};
      rdata_valid_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      dram_ras_n_o <= !n_ras;
      dram_cas_n_o <= !n_cas;
      dram_wr_n_o <= !(wr_lead || wr_hold);
      dram_rd_n_o <= !(rd_lead || rd_hold);
      if (addr_load) begin
        dram_addr_o <= up_addr;
      end
      if (data_load) begin
        dram_dq_o <= up_data;
      end
      // Drivers wait three ticks so a read driver can let go
      if (!dram_wr_n_o) begin
        if (wr_age != 2'h3) begin
          wr_age <= wr_age + 2'h1;
        end
      end else begin
        wr_age <= 2'h0;
      end
      dram_dq_oe_o <= !dram_wr_n_o && (wr_age >= `DPMT_OE_AGE);
      req_ready_o <= accept_idle || accept_col;
      // Sampled on the last tick the column strobe is still low
      if (rd_capture) begin
        rdata_o <= dram_dq_i;
      end
      rdata_valid_o <= rd_capture;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // Refresh timer counts whole core periods; zero disables it
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ref_pre <= 2'h0;
      ref_cnt <= {`DPMT_REF_W{1'b0}};
      refresh_req_o <= 1'b0;
    end else begin
      refresh_req_o <= 1'b0;
      if (ref_pre == `DPMT_TICKS_PER_TC) begin
        ref_pre <= 2'h0;
      end else begin
        ref_pre <= ref_pre + 2'h1;
      end
      if (refresh_interval_i == {`DPMT_REF_W{1'b0}}) begin
        ref_cnt <= {`DPMT_REF_W{1'b0}};
      end else if (ref_pre == `DPMT_TICKS_PER_TC) begin
        if (ref_cnt == {`DPMT_REF_W{1'b0}}) begin
          refresh_req_o <= 1'b1;
          ref_cnt <= refresh_interval_i - {{(`DPMT_REF_W-1){1'b0}}, 1'b1};
        end else begin
          ref_cnt <= ref_cnt - {{(`DPMT_REF_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // dpmt_sequencer

// ---- verilog/dpmt_defines.vh ----
`ifndef DPMT_DEFINES_VH
`define DPMT_DEFINES_VH

// One sys_clk tick is one quarter of the core period T_C
`define DPMT_TICKS_PER_TC 2'h3
`define DPMT_COL_W 12
`define DPMT_DATA_W 24
`define DPMT_REF_W 8
// Write strobe age at which the data drivers are switched on
`define DPMT_OE_AGE 2'h2

// Page wait-state codes
`define DPMT_WS1 2'h1
`define DPMT_WS2 2'h2
`define DPMT_WS3 2'h3

// Timings in quarter T_C ticks: one, two, three wait states
// Column address valid to column strobe: 0.5, 1, 1 T_C
`define DPMT_W1_ASC 6'h02
`define DPMT_W2_ASC 6'h04
`define DPMT_W3_ASC 6'h04
// Column strobe low width: 0.75, 1.5, 2 T_C
`define DPMT_W1_CASW 6'h03
`define DPMT_W2_CASW 6'h06
`define DPMT_W3_CASW 6'h08
// Column strobe high width: 0.5, 1.25, 1.5 T_C
`define DPMT_W1_CP 6'h02
`define DPMT_W2_CP 6'h05
`define DPMT_W3_CP 6'h06
// Write strobe low to column strobe low: 1, 1, 1.25 T_C
`define DPMT_W1_WCS 6'h04
`define DPMT_W2_WCS 6'h04
`define DPMT_W3_WCS 6'h05
// Column strobe low to write strobe high: 0.5, 1.5, 2.25 T_C
`define DPMT_W1_WCH 6'h02
`define DPMT_W2_WCH 6'h06
`define DPMT_W3_WCH 6'h09
// Write data valid to column strobe low: 0.25, 0.25, 0.5 T_C
`define DPMT_W1_DS 6'h01
`define DPMT_W2_DS 6'h01
`define DPMT_W3_DS 6'h02
// Column strobe high to write strobe low after a read: 0.25, 0.5, 0.75 T_C
`define DPMT_W1_RCH 6'h01
`define DPMT_W2_RCH 6'h02
`define DPMT_W3_RCH 6'h03
// Last column strobe high to row strobe high, selector 00..11
`define DPMT_W1_CRP0 6'h07
`define DPMT_W1_CRP1 6'h0d
`define DPMT_W1_CRP2 6'h11
`define DPMT_W1_CRP3 6'h19
`define DPMT_W2_CRP0 6'h08
`define DPMT_W2_CRP1 6'h0e
`define DPMT_W2_CRP2 6'h12
`define DPMT_W2_CRP3 6'h1a
`define DPMT_W3_CRP0 6'h09
`define DPMT_W3_CRP1 6'h0f
`define DPMT_W3_CRP2 6'h13
`define DPMT_W3_CRP3 6'h1b

`endif

// ---- bench/dpmt_sequencer_asserts.sv ----
`timescale 1ns/1ns
module dpmt_checker (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire dram_ras_n_o,
  input wire dram_cas_n_o,
  input wire dram_wr_n_o,
  input wire dram_rd_n_o,
  input wire dram_dq_oe_o,
  input wire [11:0] dram_addr_o,
  input wire rdata_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Floors of the fastest set; slower sets only stretch them
  a_cas_low_min: assert property ($fell(dram_cas_n_o) |=> !dram_cas_n_o [*2])
    else $error("column strobe pulse too short");
  a_cas_gap_min: assert property ($rose(dram_cas_n_o) && !dram_ras_n_o |=> dram_cas_n_o)
    else $error("column strobe gap too short");
  a_ras_after_cas: assert property ($rose(dram_ras_n_o) |->
    $past(dram_cas_n_o) && $past(dram_cas_n_o, 7))
    else $error("row strobe released too soon");
  a_rd_after_cas: assert property ($rose(dram_rd_n_o) |-> $past(dram_cas_n_o))
    else $error("read strobe released before column strobe");
  a_rd_wr_apart: assert property (!dram_rd_n_o |-> dram_wr_n_o)
    else $error("write strobe active during read");
  a_oe_after_wr: assert property ($rose(dram_dq_oe_o) |->
    !dram_wr_n_o && $past(!dram_wr_n_o, 3))
    else $error("data drivers on too early");
  a_oe_off_wr: assert property ($rose(dram_wr_n_o) |=> !dram_dq_oe_o)
    else $error("data drivers left on");
  a_addr_hold: assert property (!dram_cas_n_o |-> $stable(dram_addr_o))
    else $error("column address moved under strobe");
  // Data is taken on the edge that raises the column strobe
  a_rdata_cas_rise: assert property (rdata_valid_o |->
    dram_cas_n_o && !$past(dram_cas_n_o))
    else $error("read data not taken at strobe release");
endmodule // dpmt_checker

bind dpmt_sequencer dpmt_checker u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .dram_ras_n_o(dram_ras_n_o), .dram_cas_n_o(dram_cas_n_o), .dram_wr_n_o(dram_wr_n_o),
  .dram_rd_n_o(dram_rd_n_o), .dram_dq_oe_o(dram_dq_oe_o), .dram_addr_o(dram_addr_o),
  .rdata_valid_o(rdata_valid_o));

// ---- bench/dpmt_dram_model.sv ----
`timescale 1ns/1ns
module dpmt_dram_model (
  input wire sys_clk_i,
  input wire slow_i,
  input wire cas_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire dq_oe_i,
  input wire [11:0] addr_i,
  input wire [23:0] dq_i,
  output reg [23:0] dq_o
);
  reg [23:0] mem [0:15];
  reg [1:0] lat = 2'h0;
  initial dq_o = 24'h5a_5a5a;
  always @(posedge sys_clk_i) begin
    if (!cas_n_i && !wr_n_i && dq_oe_i)
      mem[addr_i[3:0]] <= dq_i;
    // Undriven bus toggles so a late sample reads wrong
    if (!cas_n_i && !rd_n_i) begin
      // Saturate so a long strobe never falls back to the slow phase
      if (lat != 2'h3)
        lat <= lat + 2'h1;
      dq_o <= (lat >= {1'b0, slow_i}) ? mem[addr_i[3:0]] : ~dq_o;
    end else begin
      lat <= 2'h0;
      dq_o <= ~dq_o;
    end
  end
endmodule // dpmt_dram_model

// ---- bench/dpmt_sequencer_bench.sv ----
`timescale 1ns/1ns
module dpmt_sequencer_bench;
  reg sys_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg req_valid_i = 1'b0;
  reg req_write_i = 1'b0;
  reg [11:0] req_col_addr_i = 12'h000;
  reg [23:0] req_wdata_i = 24'h00_0000;
  reg [1:0] ws = 2'h2;
  reg [1:0] brw = 2'h0;
  reg [7:0] refi = 8'h05;
  reg slow = 1'b0;
  wire [23:0] dq_in, rdata_o, dq_out;
  wire [11:0] addr;
  wire ready, rdata_valid_o, refresh, busy, ras_n, cas_n, wr_n, rd_n, oe;
  integer miscompares = 0;
  integer n_tests = 0;
  integer run = 0, rcnt = 0, w, b, m, n;
  reg [15:0] rnd = 16'h88a1;
  reg [23:0] em [0:15];
  reg [23:0] eq [$];
  reg pcas = 1'b1, pras = 1'b1, rseen = 1'b0;

  dpmt_sequencer dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_col_addr_i(req_col_addr_i),
    .req_wdata_i(req_wdata_i), .page_wait_states_i(ws), .out_of_page_wait_select_i(brw),
    .refresh_interval_i(refi), .dram_dq_i(dq_in), .req_ready_o(ready), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .refresh_req_o(refresh), .busy_o(busy),
    .dram_ras_n_o(ras_n), .dram_cas_n_o(cas_n), .dram_wr_n_o(wr_n), .dram_rd_n_o(rd_n),
    .dram_addr_o(addr), .dram_dq_o(dq_out), .dram_dq_oe_o(oe));
  dpmt_dram_model ram (.sys_clk_i(sys_clk_i), .slow_i(slow), .cas_n_i(cas_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .dq_oe_i(oe), .addr_i(addr), .dq_i(dq_out), .dq_o(dq_in));

  initial forever #10 sys_clk_i = ~sys_clk_i;

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function integer casw(input [1:0] k);
    casw = (k == 2'h1) ? 3 : (k == 2'h2) ? 6 : 8;
  endfunction
  function integer crp(input [1:0] k, input [1:0] s);
    crp = (s == 2'h0 ? 7 : s == 2'h1 ? 13 : s == 2'h2 ? 17 : 25) + (k == 2'h0 ? 2 : k - 1);
  endfunction

  task note(input [31:0] got, input [31:0] exp);
    begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_ticks(input integer got, input integer exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) note(got, exp);
    end
  endtask
  task chk_data(input [23:0] got, input [23:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) note(got, exp);
    end
  endtask

  // Next request goes up on the edge that sees ready, so a burst never lapses
  task col(input wr, input [3:0] a);
    begin
      rnd = lfsr(rnd);
      req_write_i <= wr;
      req_col_addr_i <= {rnd[15:12], 4'h0, a};
      req_wdata_i <= {rnd[7:0], rnd};
      req_valid_i <= 1'b1;
      if (wr) em[a] = {rnd[7:0], rnd};
      else eq.push_back(em[a]);
      n = 0;
      do begin @(posedge sys_clk_i); n = n + 1; end while (ready !== 1'b1 && n < 300);
      if (n >= 300) note(0, 1);
    end
  endtask
  task burst(input [1:0] kind, input integer len);
    integer j;
    integer ad;
    begin
      for (j = 0; j < len; j = j + 1) begin
        // Mixed bursts read back the column written just before
        ad = (kind == 2'h2) ? j - j % 2 : j;
        col(kind == 2'h0 || (kind == 2'h2 && j % 2 == 0), ad[3:0]);
      end
      req_valid_i <= 1'b0;
      n = 0;
      do begin @(posedge sys_clk_i); n = n + 1; end while (busy !== 1'b0 && n < 300);
      if (n >= 300) note(0, 1);
    end
  endtask

  always @(posedge sys_clk_i) begin
    run <= (cas_n !== pcas) ? 1 : run + 1;
    rcnt <= refresh ? 1 : rcnt + 1;
    pcas <= cas_n;
    pras <= ras_n;
    if (!sys_rst_i) begin
      if (cas_n && !pcas) chk_ticks(run, casw(ws));
      if (ras_n && !pras) chk_ticks(run, crp(ws, brw));
      if (refresh && rseen) chk_ticks(rcnt, 4 * refi);
      if (refresh) rseen <= 1'b1;
      if (rdata_valid_o) chk_data(rdata_o, eq.pop_front());
    end
  end

  task final_report;
    begin
      $display("checks %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #800000;
    note(0, 1);
    final_report;
  end

  initial begin
    rnd = lfsr(rnd);
    refi <= {5'h00, rnd[2:0]} | 8'h01;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    // Code 0 of the wait field runs as the three-state set
    for (w = 0; w < 4; w = w + 1)
      for (b = 0; b < 4; b = b + 1) begin
        ws <= w[1:0];
        brw <= b[1:0];
        slow <= b[0];
        rnd = lfsr(rnd);
        m = 1 + rnd[3:0] % 3;
        burst(2'h0, m);
        burst(2'h1, m);
        burst(2'h2, m + 1);
      end
    chk_ticks(eq.size(), 0);
    final_report;
  end
endmodule // dpmt_sequencer_bench
